/* port_power_pkg.sv */
`default_nettype none
package port_power_pkg;

    // Clock rate and timing figures
    localparam int unsigned CLK_MHZ           = 200;
    localparam int unsigned T_CYCLE_US        = 20000;
    localparam int unsigned T_FAULT_TEST_US   = 10;
    localparam int unsigned T_ATTACH_QUAL_US  = 500;
    localparam int unsigned T_REMOVE_QUAL_US  = 500;
    localparam int unsigned T_DISCHARGE_US    = 100;
    localparam int unsigned T_CDP_ANSWER_MS   = 20;

    // Cycle counts derived from the figures
    localparam int unsigned CYCLE_CNT_DEF     = T_CYCLE_US * CLK_MHZ;
    localparam int unsigned TEST_CNT_DEF      = T_FAULT_TEST_US * CLK_MHZ;
    localparam int unsigned ATT_QUAL_CNT_DEF  = T_ATTACH_QUAL_US * CLK_MHZ;
    localparam int unsigned REM_QUAL_CNT_DEF  = T_REMOVE_QUAL_US * CLK_MHZ;
    localparam int unsigned DISCH_CNT_DEF     = T_DISCHARGE_US * CLK_MHZ;
    localparam int unsigned CDP_ANSWER_CNT    = T_CDP_ANSWER_MS * 1000 * CLK_MHZ;

    // Register byte addresses
    localparam logic [7:0]  ADDR_CTRL         = 8'h00;
    localparam logic [7:0]  ADDR_STATUS       = 8'h04;

    // Control register layout, most significant field first
    typedef struct packed {
        logic bus_fault_sel;
        logic port_power_enable;
        logic mode_select_2;
        logic mode_select_1;
        logic emulation_enable;
        logic detection_enable;
        logic latch_select;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = 7'h40;

    // Status register layout
    typedef struct packed {
        logic [22:0] zero;
        logic        handshake_ok;
        logic [3:0]  state;
        logic        attach_pin_flag;
        logic        removal_status_flag;
        logic        attach_status_flag;
        logic        error_flag;
    } stat_t;

    // Comparator and pin inputs from the analog side
    typedef struct packed {
        logic [5:0] fault;
        logic       load_attach;
        logic       load_remove;
        logic       main_supply;
        logic       port_data_pos;
        logic       latch_pin;
    } sense_t;

    // Switch and profile drives
    typedef struct packed {
        logic bypass_sw;
        logic port_sw;
        logic discharge;
        logic hs_sw;
        logic cc_limit;
        logic dcp_short;
        logic cdp_profile;
        logic emul_cycle;
        logic emul_timeout_en;
        logic port_data_neg;
    } drive_t;

    typedef enum logic [2:0] {
        MODE_NONE = 3'h0,
        MODE_EMUL = 3'h1,
        MODE_PASS = 3'h2,
        MODE_DCP  = 3'h3,
        MODE_SDP  = 3'h4,
        MODE_CDP  = 3'h5
    } mode_t;

    typedef enum logic [3:0] {
        ST_DETECT   = 4'h0,
        ST_ATTACHED = 4'h1,
        ST_RENEG    = 4'h2,
        ST_ACTIVE   = 4'h3,
        ST_REMOVE   = 4'h4,
        ST_ERR_HOLD = 4'h5,
        ST_ERR_WAIT = 4'h6,
        ST_ERR_TEST = 4'h7
    } state_t;

endpackage
`default_nettype wire

/* usb_port_power_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

module usb_port_power_ctrl #(
    parameter int unsigned CYCLE_CNT    = port_power_pkg::CYCLE_CNT_DEF,
    parameter int unsigned TEST_CNT     = port_power_pkg::TEST_CNT_DEF,
    parameter int unsigned ATT_QUAL_CNT = port_power_pkg::ATT_QUAL_CNT_DEF,
    parameter int unsigned REM_QUAL_CNT = port_power_pkg::REM_QUAL_CNT_DEF,
    parameter int unsigned DISCH_CNT    = port_power_pkg::DISCH_CNT_DEF
) (
    // Clock, reset and enable
    input  wire logic                    MCLK,
    input  wire logic                    SYS_RST,
    input  wire logic                    CE,
    // APB slave
    input  wire logic                    PSEL,
    input  wire logic                    PENABLE,
    input  wire logic                    PWRITE,
    input  wire logic [7:0]              PADDR,
    input  wire logic [31:0]             PWDATA,
    output logic [31:0]                  PRDATA,
    output logic                         PREADY,
    output logic                         PSLVERR,
    // Analog sense inputs
    input  wire port_power_pkg::sense_t  SENSE,
    // Switch and profile drives
    output port_power_pkg::drive_t       DRIVE,
    // Open-drain pins, enable high pulls low
    output logic                         ATTACH_DETECT_N_OE,
    output logic                         ALERT_N_OE
);
    import port_power_pkg::*;

    // Refuse counts that the timers cannot serve
    if (CYCLE_CNT < 1 || TEST_CNT < 1 || ATT_QUAL_CNT < 1 ||
        REM_QUAL_CNT < 1 || DISCH_CNT < 1) begin : g_bad_count
        $error("timing counts must be at least one");
    end

    sense_t      sense_meta;
    sense_t      sense;
    ctrl_t       ctrl;
    state_t      state;
    state_t      next_state;
    mode_t       cur_mode;
    mode_t       next_mode;
    mode_t       act_mode;
    drive_t      next_drive;
    logic [31:0] tmr;
    logic [31:0] next_tmr;
    logic [31:0] att_cnt;
    logic [31:0] rem_cnt;
    logic        error_flag;
    logic        attach_status_flag;
    logic        removal_status_flag;
    logic        attach_pin_flag;
    logic        handshake_ok;
    logic        ppe_prev;
    logic        data_pos_prev;

    // Two-stage synchroniser for the analog side
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            sense_meta <= '0;
            sense      <= '0;
        end else if (CE) begin
            sense_meta <= SENSE;
            sense      <= sense_meta;
        end
    end

    // APB decode
    wire logic  acc_start = PSEL && PENABLE && !PREADY;
    wire logic  acc_done  = PSEL && PENABLE && PREADY;
    wire logic  hit_ctrl  = PADDR == ADDR_CTRL;
    wire logic  hit_stat  = PADDR == ADDR_STATUS;
    wire logic  wr_ctrl   = acc_done && PWRITE && hit_ctrl;
    wire stat_t clr       = (acc_done && PWRITE && hit_stat) ? stat_t'(PWDATA) : '0;

    // Status read view
    stat_t stat_view;
    assign stat_view = '{zero: '0, handshake_ok: handshake_ok, state: state,
                         attach_pin_flag: attach_pin_flag,
                         removal_status_flag: removal_status_flag,
                         attach_status_flag: attach_status_flag,
                         error_flag: error_flag};

    wire logic [31:0] rd_word = hit_ctrl ? {25'h0, ctrl} :
                                hit_stat ? stat_view : 32'h0;

    // Bus handshake, one wait cycle per access
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0;
            PSLVERR <= 1'b0;
        end else if (CE) begin
            PREADY  <= acc_start;
            PRDATA  <= (acc_start && !PWRITE) ? rd_word : 32'h0;
            PSLVERR <= acc_start && !hit_ctrl && !hit_stat;
        end
    end

    // Control register
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            ctrl <= CTRL_RESET;
        end else if (CE && wr_ctrl) begin
            ctrl <= ctrl_t'(PWDATA[$bits(ctrl_t)-1:0]);
        end
    end

    wire logic latch_mode = ctrl.bus_fault_sel ? ctrl.latch_select : sense.latch_pin;
    wire logic fault_any  = |sense.fault;
    wire logic ppe        = ctrl.port_power_enable;
    wire logic ppe_fall   = ppe_prev && !ppe;
    wire logic retry_req  = ppe_fall || clr.error_flag;

    wire logic [2:0] msel = {ctrl.mode_select_1, ctrl.mode_select_2, ctrl.emulation_enable};
    assign act_mode = (msel == 3'h1 || msel == 3'h5) ? MODE_EMUL :
                      (msel == 3'h2 || msel == 3'h6) ? MODE_PASS :
                      (msel == 3'h3) ? MODE_DCP :
                      (msel == 3'h4) ? MODE_SDP :
                      (msel == 3'h7) ? MODE_CDP : MODE_NONE;

    wire logic act_charger = act_mode == MODE_SDP || act_mode == MODE_DCP ||
                             act_mode == MODE_CDP;
    wire logic in_error    = state == ST_ERR_HOLD || state == ST_ERR_WAIT ||
                             state == ST_ERR_TEST;
    wire logic fault_watch = state == ST_ATTACHED || state == ST_ACTIVE ||
                             state == ST_RENEG;

    wire logic att_evt = state == ST_DETECT && att_cnt == ATT_QUAL_CNT;
    wire logic rem_mon = ctrl.detection_enable &&
                         (state == ST_ATTACHED || state == ST_ACTIVE);
    wire logic rem_evt = rem_mon && rem_cnt == REM_QUAL_CNT;

    // Attach and removal qualification counters
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            att_cnt <= 32'h0;
            rem_cnt <= 32'h0;
        end else if (CE) begin
            att_cnt <= (state != ST_DETECT || !sense.load_attach) ? 32'h0 :
                       (att_evt ? att_cnt : att_cnt + 32'h1);
            rem_cnt <= (!rem_mon || !sense.load_remove) ? 32'h0 :
                       (rem_evt ? rem_cnt : rem_cnt + 32'h1);
        end
    end

    // Power state sequencing
    always_comb begin
        next_state = state;
        next_tmr   = (tmr == 32'h0) ? 32'h0 : tmr - 32'h1;
        if (fault_watch && fault_any) begin
            next_state = latch_mode ? ST_ERR_HOLD : ST_ERR_WAIT;
            next_tmr   = 32'(CYCLE_CNT - 1);
        end else if (rem_evt) begin
            next_state = ST_REMOVE;
            next_tmr   = 32'(DISCH_CNT - 1);
        end else begin
            case (state)
                ST_DETECT: begin
                    if (att_evt) begin
                        next_state = ST_ATTACHED;
                    end
                end
                ST_ATTACHED: begin
                    if (ppe && sense.main_supply) begin
                        next_state = act_charger ? ST_RENEG : ST_ACTIVE;
                        next_tmr   = 32'(DISCH_CNT - 1);
                    end
                end
                ST_ACTIVE: begin
                    if (!ppe && cur_mode != MODE_PASS) begin
                        next_state = ST_DETECT;
                    end else if (act_mode != cur_mode && act_charger) begin
                        next_state = ST_RENEG;
                        next_tmr   = 32'(DISCH_CNT - 1);
                    end
                end
                ST_RENEG: begin
                    if (tmr == 32'h0) begin
                        next_state = ST_ACTIVE;
                    end
                end
                ST_REMOVE: begin
                    if (tmr == 32'h0) begin
                        next_state = ST_DETECT;
                    end
                end
                ST_ERR_WAIT: begin
                    if (tmr == 32'h0) begin
                        next_state = ST_ERR_TEST;
                        next_tmr   = 32'(TEST_CNT - 1);
                    end
                end
                ST_ERR_TEST: begin
                    if (fault_any) begin
                        next_state = ST_ERR_WAIT;
                        next_tmr   = 32'(CYCLE_CNT - 1);
                    end else if (tmr == 32'h0) begin
                        next_state = ST_ACTIVE;
                    end
                end
                ST_ERR_HOLD: begin
                    if (retry_req && !fault_any) begin
                        next_state = ST_ACTIVE;
                    end
                end
                default: begin
                    next_state = ST_DETECT;
                end
            endcase
        end
    end

    // Mode follows the control bits whenever the next state is active, held otherwise
    assign next_mode = (next_state == ST_ACTIVE) ? act_mode : cur_mode;

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            state    <= ST_DETECT;
            tmr      <= 32'h0;
            cur_mode <= MODE_NONE;
            ppe_prev <= 1'b0;
        end else if (CE) begin
            state    <= next_state;
            tmr      <= next_tmr;
            cur_mode <= next_mode;
            ppe_prev <= ppe;
        end
    end

    // Drive decode from the next state
    wire logic nx_active = next_state == ST_ACTIVE;
    wire logic nx_cdp    = nx_active && next_mode == MODE_CDP;
    wire logic nx_dcp    = nx_active && next_mode == MODE_DCP;
    wire logic nx_emul   = nx_active && next_mode == MODE_EMUL;
    // one supply path at a time
    assign next_drive.bypass_sw = next_state == ST_DETECT || next_state == ST_ATTACHED;
    assign next_drive.port_sw   = nx_active;
    assign next_drive.discharge = next_state == ST_RENEG || next_state == ST_REMOVE;
    assign next_drive.hs_sw     = nx_active && (next_mode == MODE_PASS ||
                                  next_mode == MODE_SDP || next_mode == MODE_CDP);
    assign next_drive.cc_limit  = nx_cdp || nx_dcp;
    assign next_drive.dcp_short = nx_dcp;
    assign next_drive.cdp_profile     = nx_cdp;
    assign next_drive.emul_cycle      = nx_emul;
    assign next_drive.emul_timeout_en = nx_emul;
    // answer while data line is mid level
    assign next_drive.port_data_neg   = nx_cdp && sense.port_data_pos;

    // Drive and attach pin registers
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            DRIVE              <= '0;
            ATTACH_DETECT_N_OE <= 1'b0;
        end else if (CE) begin
            DRIVE <= next_drive;
            ATTACH_DETECT_N_OE <= att_evt || (ATTACH_DETECT_N_OE && !rem_evt);
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            ALERT_N_OE <= 1'b0;
        end else if (CE) begin
            ALERT_N_OE <= (next_state == ST_ERR_HOLD) || (next_state == ST_ERR_WAIT) ||
                          (next_state == ST_ERR_TEST) || fault_any;
        end
    end

    // Sticky flags, a set beats a clear
    wire logic err_set = fault_watch && fault_any;
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            error_flag          <= 1'b0;
            attach_status_flag  <= 1'b0;
            attach_pin_flag     <= 1'b0;
            removal_status_flag <= 1'b0;
        end else if (CE) begin
            error_flag          <= err_set || (error_flag && !clr.error_flag);
            attach_status_flag  <= att_evt || (attach_status_flag && !clr.attach_status_flag);
            attach_pin_flag     <= att_evt || (attach_pin_flag && !clr.attach_pin_flag);
            removal_status_flag <= rem_evt || (removal_status_flag &&
                                               !clr.removal_status_flag);
        end
    end

    // CDP handshake completes when the data line falls back
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            data_pos_prev <= 1'b0;
            handshake_ok  <= 1'b0;
        end else if (CE) begin
            data_pos_prev <= sense.port_data_pos;
            handshake_ok  <= nx_cdp && (handshake_ok ||
                             (data_pos_prev && !sense.port_data_pos));
        end
    end

    property p_switch_excl;
        @(posedge MCLK) disable iff (SYS_RST || !CE)
        !(DRIVE.port_sw && DRIVE.bypass_sw);
    endproperty
    a_switch_excl: assert property (p_switch_excl)
        else $error("bypass and port switch on together");

    property p_detect_hs;
        @(posedge MCLK) disable iff (SYS_RST || !CE)
        (state == ST_DETECT) |-> !DRIVE.hs_sw;
    endproperty
    a_detect_hs: assert property (p_detect_hs)
        else $error("high-speed switch closed in detect");

    property p_attach_origin;
        @(posedge MCLK) disable iff (SYS_RST || !CE)
        $rose(ATTACH_DETECT_N_OE) |-> $past(state) == ST_DETECT && state == ST_ATTACHED;
    endproperty
    a_attach_origin: assert property (p_attach_origin)
        else $error("attach asserted outside detect");

    property p_latch_hold;
        @(posedge MCLK) disable iff (SYS_RST || !CE)
        (state == ST_ERR_HOLD && !retry_req) |=> state == ST_ERR_HOLD && ALERT_N_OE;
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("latched error left without command");

    property p_auto_alert;
        @(posedge MCLK) disable iff (SYS_RST || !CE)
        (fault_watch && fault_any && !latch_mode) |=> state == ST_ERR_WAIT && ALERT_N_OE;
    endproperty
    a_auto_alert: assert property (p_auto_alert)
        else $error("fault did not enter error wait");

    property p_removal_seq;
        @(posedge MCLK) disable iff (SYS_RST || !CE)
        rem_evt && !(fault_watch && fault_any) |=>
            !DRIVE.port_sw && !DRIVE.bypass_sw && DRIVE.discharge &&
            !ATTACH_DETECT_N_OE && removal_status_flag;
    endproperty
    a_removal_seq: assert property (p_removal_seq)
        else $error("removal sequence wrong");

    property p_pass_drive;
        @(posedge MCLK) disable iff (SYS_RST || !CE)
        (state == ST_ACTIVE && cur_mode == MODE_PASS) |-> DRIVE.hs_sw && !DRIVE.cc_limit;
    endproperty
    a_pass_drive: assert property (p_pass_drive)
        else $error("pass-through drive wrong");

    property p_dcp_drive;
        @(posedge MCLK) disable iff (SYS_RST || !CE)
        (state == ST_ACTIVE && cur_mode == MODE_DCP) |->
            !DRIVE.hs_sw && DRIVE.cc_limit && DRIVE.dcp_short && !DRIVE.emul_timeout_en;
    endproperty
    a_dcp_drive: assert property (p_dcp_drive)
        else $error("dcp drive wrong");

    property p_cdp_answer;
        @(posedge MCLK) disable iff (SYS_RST || !CE)
        (DRIVE.cdp_profile && sense.port_data_pos && nx_cdp) |=>
            DRIVE.port_data_neg;
    endproperty
    a_cdp_answer: assert property (p_cdp_answer)
        else $error("cdp answer missing");

    property p_reneg;
        @(posedge MCLK) disable iff (SYS_RST || !CE)
        (state == ST_ACTIVE && act_charger && act_mode != cur_mode &&
         !fault_any && !rem_evt && (ppe || cur_mode == MODE_PASS)) |=>
            state == ST_RENEG && DRIVE.discharge;
    endproperty
    a_reneg: assert property (p_reneg)
        else $error("mode change without vbus cycle");

endmodule
`default_nettype wire

/* usb_device_model.sv */
`timescale 1ns/1ps
`default_nettype none
module usb_device_model (
    // Test controls
    input  wire logic                   plugged,
    input  wire logic [5:0]             fault_set,
    input  wire logic                   latch_lvl,
    input  wire logic                   dp_req,
    // Block side
    input  wire port_power_pkg::drive_t drive,
    output var port_power_pkg::sense_t  sense
);
    import port_power_pkg::*;
    logic vbus_on;
    // Load only draws while VBUS is fed
    assign vbus_on = drive.bypass_sw | drive.port_sw;
    // Sense word: faults, loads, main supply good, data line, latch pin
    // data line driven only in profile
    assign sense = {fault_set, plugged & vbus_on, ~plugged, 1'b1,
                    dp_req & drive.cdp_profile, latch_lvl};
endmodule
`default_nettype wire

/* test_usb_port_power_state_control.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
module test_usb_port_power_state_control;
    import port_power_pkg::*;
    logic MCLK, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, ATT_OE, ALERT_OE;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    sense_t      SENSE;
    drive_t      DRIVE;
    logic        plugged, latch_lvl, dp_req, saw_dis, overlap, err, ce;
    logic [5:0]  fault_set;
    int          failures, cmp_count;
    // Mode code, expected drives, discharge seen
    logic [9:0]  tbl [7] = '{10'b111_111000_1, 10'b011_010100_1, 10'b100_100000_1,
        10'b110_100000_0, 10'b001_000011_0, 10'b010_100000_0, 10'b101_000011_0};

    usb_port_power_ctrl #(.CYCLE_CNT(8), .TEST_CNT(4), .ATT_QUAL_CNT(5),
        .REM_QUAL_CNT(5), .DISCH_CNT(6)) usb_port_power_ctrl_inst (
        .MCLK(MCLK), .SYS_RST(SYS_RST), .CE(ce), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .SENSE(SENSE), .DRIVE(DRIVE),
        .ATTACH_DETECT_N_OE(ATT_OE), .ALERT_N_OE(ALERT_OE));
    usb_device_model usb_device_model_inst (.plugged(plugged), .fault_set(fault_set),
        .latch_lvl(latch_lvl), .dp_req(dp_req), .drive(DRIVE), .sense(SENSE));

    // Clock
    initial begin
        MCLK = 1'b0;
        forever #2.5 MCLK = ~MCLK;
    end
    // Remember discharge pulses and any switch overlap
    always @(posedge MCLK) begin
        if (DRIVE.discharge) saw_dis <= 1'b1;
        if (DRIVE.bypass_sw & DRIVE.port_sw) overlap <= 1'b1;
    end
    // Report and end
    task automatic close_out;
        $display("mismatches %0d compares %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // One APB transfer; data taken at the edge that samples ready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge MCLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin @(posedge MCLK); n++; end while (PREADY !== 1'b1 && n < 20);
        if (PREADY !== 1'b1) begin failures++; close_out(); end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    // Poll the state field until it matches
    task automatic wait_st(input logic [3:0] s);
        int n;
        n = 0;
        do begin apb(0, ADDR_STATUS, 0); n++; end while (rd[7:4] !== s && n < 300);
        `CHK(rd[7:4], s)
        if (rd[7:4] !== s) close_out();
    endtask
    task automatic t_reset;
        apb(0, ADDR_CTRL, 0);
        `CHK(rd, 32'h40)
        apb(0, 8'h08, 32'hFFFFFFFF);
        `CHK({err, rd}, 33'h100000000)
        `CHK({DRIVE.bypass_sw, DRIVE.port_sw, DRIVE.hs_sw}, 3'b100)
    endtask
    task automatic t_attach;
        // Clock enable low must freeze attach qualification
        @(posedge MCLK);
        ce <= 1'b0;
        plugged <= 1'b1;
        repeat (20) @(posedge MCLK);
        `CHK(ATT_OE, 1'b0)
        ce <= 1'b1;
        wait_st(4'h1);
        `CHK(ATT_OE, 1'b1)
        apb(0, ADDR_STATUS, 0);
        `CHK({rd[7:4], rd[3], rd[1]}, 6'h07)
        apb(1, ADDR_CTRL, 32'h70);
        wait_st(4'h3);
        `CHK({DRIVE.bypass_sw, DRIVE.port_sw, DRIVE.hs_sw, DRIVE.cc_limit}, 4'h6)
    endtask
    task automatic t_modes;
        logic [2:0] m;
        logic [5:0] got;
        foreach (tbl[i]) begin
            m = tbl[i][9:7];
            saw_dis <= 1'b0;
            apb(1, ADDR_CTRL, {25'h0, 2'b11, m[1], m[2], m[0], 2'b00});
            wait_st(4'h3);
            got = {DRIVE.hs_sw, DRIVE.cc_limit, DRIVE.cdp_profile, DRIVE.dcp_short,
                   DRIVE.emul_cycle, DRIVE.emul_timeout_en};
            `CHK({got, saw_dis}, tbl[i][6:0])
        end
    endtask
    // Portable device steps the data line; answer must follow
    task automatic dp_step(input logic v);
        int n;
        @(posedge MCLK);
        dp_req <= v;
        n = 0;
        do begin @(negedge MCLK); n++; end while (DRIVE.port_data_neg !== v && n < 40);
        `CHK(DRIVE.port_data_neg, v)
    endtask
    task automatic t_cdp;
        apb(1, ADDR_CTRL, 32'h7C);
        wait_st(4'h3);
        dp_step(1'b1);
        dp_step(1'b0);
        apb(0, ADDR_STATUS, 0);
        `CHK(rd[8], 1'b1)
        `CHK({DRIVE.hs_sw, DRIVE.cc_limit}, 2'b11)
    endtask
    task automatic t_auto;
        latch_lvl <= 1'b1;
        apb(1, ADDR_CTRL, 32'h70);
        for (int i = 0; i < 6; i++) begin
            fault_set <= 6'h01 << i;
            wait_st(4'h6);
            `CHK({ALERT_OE, DRIVE.port_sw}, 2'b10)
            fault_set <= 6'h00;
            wait_st(4'h3);
            `CHK({ALERT_OE, DRIVE.port_sw}, 2'b01)
        end
    endtask
    task automatic t_latch;
        latch_lvl <= 1'b0;
        apb(1, ADDR_CTRL, 32'h71);
        fault_set <= 6'h01;
        wait_st(4'h5);
        fault_set <= 6'h00;
        repeat (5) apb(0, ADDR_STATUS, 0);
        `CHK({rd[7:4], ALERT_OE, DRIVE.port_sw}, 6'h16)
        apb(1, ADDR_STATUS, 32'h1);
        wait_st(4'h3);
        latch_lvl <= 1'b1;
        apb(1, ADDR_CTRL, 32'h30);
        fault_set <= 6'h01;
        wait_st(4'h5);
        fault_set <= 6'h00;
        apb(1, ADDR_CTRL, 32'h10);
        wait_st(4'h3);
        `CHK(DRIVE.hs_sw, 1'b1)
        apb(1, ADDR_CTRL, 32'h30);
    endtask
    task automatic t_remove;
        apb(1, ADDR_CTRL, 32'h6A);
        wait_st(4'h3);
        saw_dis <= 1'b0;
        plugged <= 1'b0;
        wait_st(4'h0);
        `CHK({saw_dis, ATT_OE, DRIVE.bypass_sw, DRIVE.port_sw}, 4'hA)
        `CHK(rd[2], 1'b1)
        `CHK(overlap, 1'b0)
    endtask
    // Main sequence
    initial begin
        SYS_RST = 1'b1;
        ce = 1'b1;
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
        {plugged, latch_lvl, dp_req, saw_dis, overlap, fault_set} = '0;
        failures = 0;
        cmp_count = 0;
        repeat (8) @(posedge MCLK);
        SYS_RST <= 1'b0;
        t_reset();
        t_attach();
        t_modes();
        t_cdp();
        t_auto();
        t_latch();
        t_remove();
        close_out();
    end
endmodule
`default_nettype wire
